// file: logic/lcd_segment_column_loader.v
// Notes on behaviour
// - Take pixel inputs at shift falls when selected
// - Line pulse fall copies all 80 bits
// - Width select low four bits, high eight
// - Four or two beats make one word
// - Five words fill latch, group advances
// - Scan direction sets fill order
// - Narrow mode segment mapping per transfer
// - Wide mode segment mapping per transfer
// - Scan direction picks cascade port roles
// - Select on low cascade input, drop after 80
// - Cascade output low one shift period
// - Ignore shift clock after 80 bits
// - Line pulse resets sequencing, waits select
// - Level from frame and bit, blank forces 0
// - Blank clears line latch, loading continues
// - After blank, deselect until next line
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`include "lcd_segment_column_loader_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module lcd_segment_column_loader (
   input wire clock,
   input wire rst,
   input wire shiftClock,
   input wire lineLatchPulse,
   input wire widthSelect,
   input wire scanDirection,
   input wire blankControl,
   input wire framePolarity,
   input wire [7:0] pixelInputs,
   input wire cascadeAIn,
   output reg cascadeAOut,
   output reg cascadeAOe,
   input wire cascadeBIn,
   output reg cascadeBOut,
   output reg cascadeBOe,
   output reg [159:0] segmentOutputs,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest
);

   localparam [2:0] ST_WAIT = 3'b001;
   localparam [2:0] ST_SEL = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [15:0] placeBeat;
      input [15:0] cur;
      input [1:0] beat;
      input wide;
      input [7:0] pix;
      integer j;
      begin
         placeBeat = cur;
         for (j = 0; j < 8; j = j + 1) begin
            if (wide) begin
               placeBeat[beat * 8 + 7 - j] = pix[j];
            end else if (j < 4) begin
               placeBeat[beat * 4 + 3 - j] = pix[j];
            end
         end
      end
   endfunction

   function [15:0] reverseWord;
      input [15:0] w;
      integer k;
      begin
         reverseWord = 16'h0000;
         for (k = 0; k < 16; k = k + 1) begin
            reverseWord[k] = w[15 - k];
         end
      end
   endfunction

   function [1:0] levelOf;
      input blanked;
      input frame;
      input bitValue;
      begin
         if (blanked) begin
            levelOf = `LEVEL_0;
         end else begin
            case ({frame, bitValue})
               2'b00: levelOf = `LEVEL_2;
               2'b01: levelOf = `LEVEL_0;
               2'b10: levelOf = `LEVEL_3;
               default: levelOf = `LEVEL_5;
            endcase
         end
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // A pin change is accepted once the second and third stages agree,
   // which rejects single-sample glitches on the slow panel wiring.
   wire [15:0] pinRaw;
   reg [15:0] sync1;
   reg [15:0] sync2;
   reg [15:0] sync3;
   reg [15:0] pinLevel;
   reg [7:0] pixelPrev;

   assign pinRaw = {cascadeBIn, cascadeAIn, pixelInputs, framePolarity,
                    blankControl, scanDirection, widthSelect,
                    lineLatchPulse, shiftClock};

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1 <= `PIN_RESET;
         sync2 <= `PIN_RESET;
         sync3 <= `PIN_RESET;
         pixelPrev <= 8'h00;
      end else begin
         sync1 <= pinRaw;
         sync2 <= sync1;
         sync3 <= sync2;
         pixelPrev <= sync3[`PIN_PIXEL_HI:`PIN_PIXEL_LO];
      end
   end

   genvar p;
   generate
      for (p = 0; p < `PIN_COUNT; p = p + 1) begin : pinFilter
         always @(posedge clock or posedge rst) begin
            if (rst) begin
               pinLevel[p] <= 1'b0;
            end else if (sync2[p] == sync3[p]) begin
               pinLevel[p] <= sync3[p];
            end
         end
      end
   endgenerate

   wire shiftFall;
   wire lineFall;
   wire wide;
   wire scanHigh;
   wire cascadeIn;
   reg softBlank;
   wire blankActive;

   assign shiftFall = pinLevel[`PIN_SHIFT] & ~sync2[`PIN_SHIFT] & ~sync3[`PIN_SHIFT];
   assign lineFall = pinLevel[`PIN_LINE] & ~sync2[`PIN_LINE] & ~sync3[`PIN_LINE];
   assign wide = pinLevel[`PIN_WIDTH];
   assign scanHigh = pinLevel[`PIN_SCAN];
   // Scan low samples port b, scan high samples port a
   assign cascadeIn = scanHigh ? pinLevel[`PIN_CAS_A] : pinLevel[`PIN_CAS_B];
   assign blankActive = ~pinLevel[`PIN_BLANK] | softBlank;

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   reg [2:0] state;
   reg [1:0] beat;
   reg [4:0] groupSel;
   reg [15:0] wordBuf;
   reg wordReady;
   reg cascadeLow;
   wire takeBeat;
   wire lastBeat;

   // Beats outside the selected window are dropped, standing in for
   // the gated internal clock.
   assign takeBeat = shiftFall & ((state == ST_SEL) |
                     ((state == ST_WAIT) & ~cascadeIn));
   assign lastBeat = (beat == (wide ? `BEATS_WIDE : `BEATS_NARROW));

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_WAIT;
         beat <= 2'h0;
         groupSel <= `GROUP_FIRST;
         wordBuf <= 16'h0000;
         wordReady <= 1'b0;
         cascadeLow <= 1'b0;
      end else if (lineFall) begin
         state <= ST_WAIT;
         beat <= 2'h0;
         groupSel <= `GROUP_FIRST;
         wordReady <= 1'b0;
         cascadeLow <= 1'b0;
      end else begin
         wordReady <= 1'b0;
         if (wordReady) begin
            groupSel <= {groupSel[3:0], 1'b0};
         end
         if (shiftFall & cascadeLow) begin
            cascadeLow <= 1'b0;
         end
         if (takeBeat) begin
            wordBuf <= placeBeat(wordBuf, beat, wide, pixelPrev);
            if (lastBeat) begin
               beat <= 2'h0;
               wordReady <= 1'b1;
            end else begin
               beat <= beat + 2'h1;
            end
            case (state)
               ST_WAIT: state <= ST_SEL;
               ST_SEL: state <= ST_SEL;
               default: state <= ST_DONE;
            endcase
            if (lastBeat & groupSel[4]) begin
               state <= ST_DONE;
               cascadeLow <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Data latch and line latch
   // ----------------------------------------
   reg [15:0] dataSlice [0:4];
   reg [79:0] lineLatch;
   integer s;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (s = 0; s < `GROUP_COUNT; s = s + 1) begin
            dataSlice[s] <= 16'h0000;
         end
      end else if (wordReady & ~lineFall) begin
         // Loading goes on whatever the blank input does
         for (s = 0; s < `GROUP_COUNT; s = s + 1) begin
            if (scanHigh & groupSel[s]) begin
               dataSlice[s] <= wordBuf;
            end else if (~scanHigh & groupSel[4 - s]) begin
               dataSlice[s] <= reverseWord(wordBuf);
            end
         end
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         lineLatch <= 80'h0;
      end else if (blankActive) begin
         lineLatch <= 80'h0;
      end else if (lineFall) begin
         lineLatch <= {dataSlice[4], dataSlice[3], dataSlice[2],
                       dataSlice[1], dataSlice[0]};
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   integer i;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         segmentOutputs <= 160'h0;
         cascadeAOut <= 1'b1;
         cascadeBOut <= 1'b1;
         cascadeAOe <= 1'b0;
         cascadeBOe <= 1'b0;
      end else begin
         for (i = 0; i < `SEG_COUNT; i = i + 1) begin
            segmentOutputs[2 * i +: 2] <= levelOf(blankActive,
               pinLevel[`PIN_FRAME], lineLatch[i]);
         end
         cascadeAOut <= ~cascadeLow;
         cascadeBOut <= ~cascadeLow;
         cascadeAOe <= ~scanHigh;
         cascadeBOe <= scanHigh;
      end
   end

   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   // Answers one cycle after a request is seen; the write lands on the
   // edge where waitrequest is sampled low.
   wire busReq;
   wire busTake;
   assign busReq = read | write;
   assign busTake = busReq & ~waitrequest;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
         softBlank <= `CTRL_RESET;
      end else begin
         waitrequest <= ~(busReq & waitrequest);
         if (busTake & write & byteenable[0] & (address == `CTRL_OFFSET)) begin
            softBlank <= writedata[`CTRL_SOFT_BLANK];
         end
         if (busReq & waitrequest & read) begin
            readdata <= 32'h00000000;
            case (address)
               `CTRL_OFFSET: readdata[`CTRL_SOFT_BLANK] <= softBlank;
               `STATUS_OFFSET: begin
                  readdata[`STAT_STATE_LO +: 3] <= state;
                  readdata[`STAT_CAS_LOW] <= cascadeLow;
                  readdata[`STAT_GROUP_LO +: 5] <= groupSel;
                  readdata[`STAT_BEAT_LO +: 2] <= beat;
                  readdata[`STAT_WIDE] <= wide;
                  readdata[`STAT_SCAN] <= scanHigh;
               end
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: logic/lcd_segment_column_loader_regs.vh
`ifndef LCD_SEGMENT_COLUMN_LOADER_REGS_VH
`define LCD_SEGMENT_COLUMN_LOADER_REGS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SEG_COUNT 80
`define WORD_BITS 16
`define GROUP_COUNT 5
`define BEATS_NARROW 2'h3
`define BEATS_WIDE 2'h1
`define GROUP_FIRST 5'h01

// ----------------------------------------
// Pin vector positions
// ----------------------------------------
`define PIN_COUNT 16
`define PIN_SHIFT 0
`define PIN_LINE 1
`define PIN_WIDTH 2
`define PIN_SCAN 3
`define PIN_BLANK 4
`define PIN_FRAME 5
`define PIN_PIXEL_LO 6
`define PIN_PIXEL_HI 13
`define PIN_CAS_A 14
`define PIN_CAS_B 15
`define PIN_RESET 16'h0000

// ----------------------------------------
// Output level codes
// ----------------------------------------
`define LEVEL_0 2'h0
`define LEVEL_2 2'h1
`define LEVEL_3 2'h2
`define LEVEL_5 2'h3

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CTRL_SOFT_BLANK 0
`define CTRL_RESET 1'h0
`define STAT_STATE_LO 0
`define STAT_CAS_LOW 3
`define STAT_GROUP_LO 4
`define STAT_BEAT_LO 9
`define STAT_WIDE 11
`define STAT_SCAN 12

`endif

// file: dv/lcd_segment_column_loader_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_column_loader_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic lineLatchPulse,
   input wire logic scanDirection,
   input wire logic blankControl,
   input wire logic framePolarity,
   input wire logic cascadeAOut,
   input wire logic cascadeAOe,
   input wire logic cascadeBOut,
   input wire logic cascadeBOe,
   input wire logic [159:0] segmentOutputs,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest
);
   // ----
   // Checks
   // ----
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // The pin filter and the output register take five edges to follow the scan pin
   AST_PORT_ROLE: assert property ($stable(scanDirection)[*5] |->
      cascadeAOe == !scanDirection && cascadeBOe == scanDirection) else $error("port role");
   AST_OUT_SAME: assert property (cascadeAOut == cascadeBOut) else $error("outs differ");
   AST_LOW_ONE_PERIOD: assert property ($fell(cascadeAOut) |->
      !cascadeAOut[*6] ##[1:4] cascadeAOut) else $error("cascade low length");
   AST_BLANK_ZERO: assert property (!blankControl[*6] |->
      segmentOutputs == 160'h0) else $error("blank not level 0");
   // Bit 1 of a code is high only for the two levels of the high frame phase
   AST_FRAME_CODE: assert property ((blankControl && !write && $stable(framePolarity))[*8]
      |-> segmentOutputs[1] == framePolarity && segmentOutputs[159] == framePolarity)
      else $error("level code against frame");
   AST_HOLD: assert property ($stable({lineLatchPulse, framePolarity, blankControl, write})[*8]
      |-> $stable(segmentOutputs)) else $error("outputs moved without cause");
   AST_ONE_WAIT: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest
      ##1 waitrequest) else $error("wait cycle count");
   AST_LINE_IDLE: assert property (lineLatchPulse[*3] |-> cascadeAOut)
      else $error("cascade low during line pulse");
   cover property ($fell(cascadeAOut));
   cover property (!blankControl);
   cover property ($rose(write));
endmodule
bind lcd_segment_column_loader lcd_segment_column_loader_asserts u_chk (.clock(clock),
   .rst(rst), .lineLatchPulse(lineLatchPulse), .scanDirection(scanDirection),
   .blankControl(blankControl), .framePolarity(framePolarity), .cascadeAOut(cascadeAOut),
   .cascadeAOe(cascadeAOe), .cascadeBOut(cascadeBOut), .cascadeBOe(cascadeBOe),
   .segmentOutputs(segmentOutputs), .read(read), .write(write), .waitrequest(waitrequest));
`default_nettype wire

// file: dv/lcd_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_ctrl_model (
   input wire logic clock,
   output logic shiftClock,
   output logic lineLatchPulse,
   output logic enLow,
   output logic [7:0] pixelInputs
);
   // ----
   // Timing controller; width and scan selects are not pins here, the test drives them
   // ----
   initial begin
      shiftClock = 1'b1;
      lineLatchPulse = 1'b0;
      enLow = 1'b1;
      pixelInputs = 8'h00;
   end
   // Data settles three clocks before the fall and holds past the rise
   task automatic beat(input logic [7:0] d);
      pixelInputs <= d;
      repeat (3) @(posedge clock);
      shiftClock <= 1'b0;
      repeat (4) @(posedge clock);
      shiftClock <= 1'b1;
      @(posedge clock);
   endtask
   // One line, then one more beat that a finished chip must ignore
   task automatic send(input logic wide, input logic scan, input logic [79:0] img);
      int n;
      int s;
      logic [7:0] d;
      n = wide ? 8 : 4;
      @(posedge clock);
      enLow <= 1'b0;
      repeat (4) @(posedge clock);
      for (int k = 1; k <= 80 / n; k++) begin
         d = 8'h00;
         for (int j = 0; j < n; j++) begin
            s = scan ? n * k - j : 81 - n * k + j;
            d[j] = img[s - 1];
         end
         beat(d);
      end
      enLow <= 1'b1;
      beat(wide ? 8'hff : 8'h0f);
   endtask
   task automatic pulse();
      @(posedge clock);
      lineLatchPulse <= 1'b1;
      repeat (3) @(posedge clock);
      lineLatchPulse <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// file: dv/test_lcd_segment_column_loader.sv
`timescale 1ns/10ps
`default_nettype none
`include "lcd_segment_column_loader_regs.vh"
module test_lcd_segment_column_loader;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic widthSelect = 1'b0;
   logic scanDirection = 1'b0;
   logic blankControl = 1'b1;
   logic framePolarity = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'h0;
   logic shiftClock, lineLatchPulse, enLow;
   logic [7:0] pixelInputs;
   wire logic cascadeAOut, cascadeAOe, cascadeBOut, cascadeBOe, waitrequest;
   wire logic [159:0] segmentOutputs;
   wire logic [31:0] readdata;
   // Each cascade wire: the chip when it drives, else the controller
   wire logic cascadeAIn = cascadeAOe ? cascadeAOut : enLow;
   wire logic cascadeBIn = cascadeBOe ? cascadeBOut : enLow;
   int bad_count = 0;
   int cmp_count = 0;
   logic [31:0] q;
   always #20 clock = ~clock;
   // ----
   // Instances
   // ----
   lcd_ctrl_model u_ctrl (.clock(clock), .shiftClock(shiftClock),
      .lineLatchPulse(lineLatchPulse), .enLow(enLow), .pixelInputs(pixelInputs));
   lcd_segment_column_loader u_dut (.clock(clock), .rst(rst), .shiftClock(shiftClock),
      .lineLatchPulse(lineLatchPulse), .widthSelect(widthSelect),
      .scanDirection(scanDirection), .blankControl(blankControl),
      .framePolarity(framePolarity), .pixelInputs(pixelInputs), .cascadeAIn(cascadeAIn),
      .cascadeAOut(cascadeAOut), .cascadeAOe(cascadeAOe), .cascadeBIn(cascadeBIn),
      .cascadeBOut(cascadeBOut), .cascadeBOe(cascadeBOe), .segmentOutputs(segmentOutputs),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
   // ----
   // Tasks
   // ----
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [159:0] lv(input logic [79:0] img, input logic fr);
      logic [159:0] v;
      for (int n = 0; n < 80; n++)
         v[2*n +: 2] = fr ? (img[n] ? `LEVEL_5 : `LEVEL_3) : (img[n] ? `LEVEL_0 : `LEVEL_2);
      return v;
   endfunction
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      int t;
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= 4'hf;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (waitrequest !== 1'b0 && t < 50);
      if (t >= 50) begin
         bad_count++;
         report_and_stop();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic t_lines();
      logic [79:0] img;
      for (int m = 0; m < 4; m++) begin
         img = 80'h9e37_79b9_7f4a_7c15_f39c ^ {m[1:0], 78'h0};
         @(posedge clock);
         widthSelect <= m[0];
         scanDirection <= m[1];
         framePolarity <= m[0] ^ m[1];
         u_ctrl.pulse();
         u_ctrl.send(m[0], m[1], img);
         bus(1'b0, `STATUS_OFFSET, 32'h0, q);
         check("state done", 160'(q[2:0]), 160'h4);
         check("port a oe", 160'(cascadeAOe), 160'(!m[1]));
         check("port b oe", 160'(cascadeBOe), 160'(m[1]));
         check("cascade idle", 160'({cascadeAOut, cascadeBOut}), 160'h3);
         u_ctrl.pulse();
         check("line", segmentOutputs, lv(img, m[0] ^ m[1]));
         bus(1'b0, `STATUS_OFFSET, 32'h0, q);
         check("state wait", 160'(q[2:0]), 160'h1);
      end
   endtask
   task automatic t_blank();
      logic [79:0] img;
      img = 80'h0123_4567_89ab_cdef_5aa5;
      @(posedge clock);
      blankControl <= 1'b0;
      u_ctrl.send(widthSelect, scanDirection, img);
      check("blanked", segmentOutputs, 160'h0);
      @(posedge clock);
      blankControl <= 1'b1;
      repeat (8) @(posedge clock);
      check("deselect", segmentOutputs, lv(80'h0, framePolarity));
      u_ctrl.pulse();
      check("after blank", segmentOutputs, lv(img, framePolarity));
   endtask
   task automatic t_regs();
      bus(1'b1, `CTRL_OFFSET, 32'h1, q);
      repeat (6) @(posedge clock);
      check("soft blank", segmentOutputs, 160'h0);
      bus(1'b0, `CTRL_OFFSET, 32'h0, q);
      check("ctrl", 160'(q), 160'h1);
      bus(1'b1, `CTRL_OFFSET, 32'h0, q);
      bus(1'b1, 4'hc, 32'hffff_ffff, q);
      bus(1'b0, 4'hc, 32'h0, q);
      check("unmapped", 160'(q), 160'h0);
      repeat (8) @(posedge clock);
      check("soft deselect", segmentOutputs, lv(80'h0, framePolarity));
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      check("reset", segmentOutputs, 160'h0);
      t_lines();
      t_blank();
      t_regs();
      report_and_stop();
   end
   initial begin
      #2000000;
      bad_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
